//--- common/fxc_pkg.sv
// Shared constants, timing counts and types for the strobe FIFO pin controller
package fxc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and depths
   localparam int unsigned DATA_W      = 9;  // Word width on both pin buses
   localparam int unsigned BUF_DEPTH   = 8;  // Words held in the staging buffer
   localparam int unsigned CNT_W       = 8;  // Width of every phase counter
   localparam int unsigned SYNC_STAGES = 2;  // Flops ahead of any pin reader

   ////////////////////////////////////////////////////////////////////////////
   // Times in ns, slowest speed grade so any grade is served
   localparam int unsigned CLK_NS         = 10;
   localparam int unsigned T_STROBE_NS    = 120; // Read and write pulse width
   localparam int unsigned T_RECOVER_NS   = 20;  // Read, write, reset, rewind recovery
   localparam int unsigned T_FLAG_NS      = 60;  // Strobe edge to flag update
   localparam int unsigned T_ACCESS_NS    = 120; // Read low to data valid
   localparam int unsigned T_CLEAR_NS     = 120; // Master clear pulse width
   localparam int unsigned T_CLEAR_FLG_NS = 140; // Master clear to flags settled
   localparam int unsigned T_REWIND_NS    = 120; // Rewind pulse width

   // Least times round up to whole cycles
   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   // Saturating step for the pin age counters
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return (v == '1) ? v : CNT_W'(v + 8'h01);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Cycle counts; waits after an edge include the synchroniser delay
   localparam logic [CNT_W-1:0] STROBE_CYC    = CNT_W'(ns_to_cyc(T_STROBE_NS));
   localparam logic [CNT_W-1:0] RD_LOW_CYC    = CNT_W'(ns_to_cyc(T_ACCESS_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] REC_CYC       =
      CNT_W'(ns_to_cyc((T_FLAG_NS > T_RECOVER_NS) ? T_FLAG_NS : T_RECOVER_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] CLEAR_CYC     = CNT_W'(ns_to_cyc(T_CLEAR_NS));
   localparam logic [CNT_W-1:0] CLEAR_REC_CYC = CNT_W'(ns_to_cyc(T_CLEAR_FLG_NS) + SYNC_STAGES);
   localparam logic [CNT_W-1:0] REWIND_CYC    = CNT_W'(ns_to_cyc(T_REWIND_NS));
   localparam logic [CNT_W-1:0] REWIND_REC_CYC = CNT_W'(ns_to_cyc(T_RECOVER_NS) + SYNC_STAGES);

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic PIN_INACTIVE = 1'h1;  // Strobes idle high
   localparam logic CLEAR_ASSERT = 1'h0;  // Master clear held low under reset
   localparam logic SINGLE_MODE  = 1'h0;  // Chain input grounded

   typedef enum logic [3:0] {
      FXC_CLEAR, FXC_CLEAR_REC, FXC_IDLE, FXC_WR_LOW, FXC_WR_REC,
      FXC_RD_LOW, FXC_RD_REC, FXC_RT_LOW, FXC_RT_REC
   } fxc_state_e;

endpackage

//--- common/fxc_stream_if.sv
// Valid/ready word stream between the staging buffer and the pin sequencer
`timescale 1ns/1ps
`default_nettype none
interface fxc_stream_if #(parameter int unsigned W = 9);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- logic/fxc_buf.sv
// Small synchronous staging FIFO ahead of the device write port
`timescale 1ns/1ps
`default_nettype none
module fxc_buf
   import fxc_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W,
   parameter int unsigned DEPTH = BUF_DEPTH
) (
   input  wire logic             clk,      // System clock
   input  wire logic             arst_n,   // Async reset, active low
   input  wire logic [WIDTH-1:0] in_data,  // Word to store
   input  wire logic             in_valid, // Word offered
   output logic                  in_ready, // Room for a word
   fxc_stream_if.src             drain     // Drain side towards the sequencer
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             push, pop;

   // Wrap works for any depth, not only powers of two
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Honest flags; a full buffer stalls the source
   assign in_ready    = (cnt_r != CW'(DEPTH));
   assign push        = in_valid && in_ready;
   assign drain.valid = (cnt_r != '0);
   assign pop         = drain.valid && drain.ready;
   assign drain.data  = mem[rp_r];

   // Pointer and occupancy next values
   always_comb begin
      wp_nxt  = push ? ptr_inc(wp_r) : wp_r;
      rp_nxt  = pop ? ptr_inc(rp_r) : rp_r;
      cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- logic/fxc_ctrl.sv
// Pin sequencer driving an asynchronous strobe FIFO from user requests
`timescale 1ns/1ps
`default_nettype none
module fxc_ctrl
   import fxc_pkg::*;
(
   input  wire logic              clk,                   // 100 MHz clock
   input  wire logic              arst_n,                // Async reset, active low
   input  wire logic [DATA_W-1:0] in_data,               // User word to write
   input  wire logic              in_valid,              // User word offered
   output logic                   in_ready,              // Buffer has room
   input  wire logic              rd_req,                // Read one word per grant
   output logic [DATA_W-1:0]      out_data,              // Word read back
   output logic                   out_valid,             // One-cycle word pulse
   input  wire logic              clear_req,             // Pulse: master clear
   input  wire logic              rewind_req,            // Pulse: rewind reader
   output logic                   busy,                  // Sequencer not idle
   output logic                   dev_ready,             // First clear done
   output logic                   dev_empty,             // Device empty, synced
   output logic                   dev_full,              // Device full, synced
   output logic                   dev_half,              // Device half mark, synced
   output logic                   write_n,               // Write strobe pin
   output logic                   read_n,                // Read strobe pin
   output logic                   master_clear_n,        // Master clear pin
   output logic                   first_load_or_rewind_n, // Rewind pin
   output logic                   chain_input_n,         // Chain input pin
   output logic [DATA_W-1:0]      write_bus,             // Write data pins
   input  wire logic [DATA_W-1:0] read_bus,              // Read data pins
   input  wire logic              empty_flag_n,          // Empty flag pin
   input  wire logic              full_flag_n,           // Full flag pin
   input  wire logic              half_mark_n            // Half mark pin
);
   localparam int unsigned SW = DATA_W + 3;

   fxc_stream_if #(.W(DATA_W)) stage_if ();

   fxc_state_e          state_r, state_nxt;
   logic [CNT_W-1:0]    cnt_r, cnt_nxt;
   logic [DATA_W-1:0]   wdata_r, wdata_nxt, odata_r, odata_nxt;
   logic                ovalid_r, ovalid_nxt, prio_rd_r, prio_rd_nxt;
   logic                clr_pend_r, clr_pend_nxt, rt_pend_r, rt_pend_nxt;
   logic                done_r, done_nxt;
   logic                wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt, mc_n_r, mc_n_nxt, rt_n_r, rt_n_nxt;
   logic [SW-1:0]       sync1_r, sync2_r;
   logic [DATA_W-1:0]   rbus_s;
   logic                empty_n_s, full_n_s, half_n_s;
   logic                can_wr, can_rd, take_wr, take_clr, take_rt;

   ////////////////////////////////////////////////////////////////////////////
   // Staging buffer; its ready backs up to the user
   fxc_buf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk      (clk),
      .arst_n   (arst_n),
      .in_data  (in_data),
      .in_valid (in_valid),
      .in_ready (in_ready),
      .drain    (stage_if.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; only the second stage is read anywhere
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {read_bus, empty_flag_n, full_flag_n, half_mark_n};
         sync2_r <= sync1_r;
      end
   end

   assign {rbus_s, empty_n_s, full_n_s, half_n_s} = sync2_r;

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration; flags are trusted only after the recovery wait
   assign can_wr         = stage_if.valid && full_n_s;
   assign can_rd         = rd_req && empty_n_s;
   assign take_clr       = (state_r == FXC_IDLE) && clr_pend_r;
   assign take_rt        = (state_r == FXC_IDLE) && !clr_pend_r && rt_pend_r;
   assign take_wr        = (state_r == FXC_IDLE) && !clr_pend_r && !rt_pend_r &&
                           can_wr && (!can_rd || !prio_rd_r);
   assign stage_if.ready = take_wr;

   // Sequencer next state; pins are decoded from the next state so they leave flops
   always_comb begin
      state_nxt    = state_r;
      cnt_nxt      = CNT_W'(cnt_r - 8'h01);
      wdata_nxt    = wdata_r;
      odata_nxt    = odata_r;
      ovalid_nxt   = 1'h0;
      prio_rd_nxt  = prio_rd_r;
      done_nxt     = done_r;
      // A request in the cycle its pending bit is taken is kept
      clr_pend_nxt = (clr_pend_r && !take_clr) || clear_req;
      rt_pend_nxt  = (rt_pend_r && !take_rt) || rewind_req;
      unique case (state_r)
         FXC_CLEAR: begin
            if (cnt_r == 8'h01) begin
               state_nxt = FXC_CLEAR_REC;
               cnt_nxt   = CLEAR_REC_CYC;
            end
         end
         FXC_CLEAR_REC: begin
            if (cnt_r == 8'h01) begin
               state_nxt = FXC_IDLE;
               done_nxt  = 1'h1;
            end
         end
         FXC_IDLE: begin
            cnt_nxt = cnt_r;
            if (take_clr) begin
               state_nxt = FXC_CLEAR;
               cnt_nxt   = CLEAR_CYC;
            end else if (take_rt) begin
               state_nxt = FXC_RT_LOW;
               cnt_nxt   = REWIND_CYC;
            end else if (take_wr) begin
               state_nxt   = FXC_WR_LOW;
               cnt_nxt     = STROBE_CYC;
               wdata_nxt   = stage_if.data;
               prio_rd_nxt = 1'h1;
            end else if (can_rd) begin
               state_nxt   = FXC_RD_LOW;
               cnt_nxt     = RD_LOW_CYC;
               prio_rd_nxt = 1'h0;
            end
         end
         FXC_WR_LOW: begin
            if (cnt_r == 8'h01) begin
               state_nxt = FXC_WR_REC;
               cnt_nxt   = REC_CYC;
            end
         end
         FXC_RD_LOW: begin
            if (cnt_r == 8'h01) begin
               state_nxt  = FXC_RD_REC;
               cnt_nxt    = REC_CYC;
               odata_nxt  = rbus_s; // Access time plus sync delay has passed
               ovalid_nxt = 1'h1;
            end
         end
         FXC_RT_LOW: begin
            if (cnt_r == 8'h01) begin
               state_nxt = FXC_RT_REC;
               cnt_nxt   = REWIND_REC_CYC;
            end
         end
         FXC_WR_REC, FXC_RD_REC, FXC_RT_REC: begin
            if (cnt_r == 8'h01) begin
               state_nxt = FXC_IDLE;
            end
         end
      endcase
      // Strobes idle high through clear and rewind
      wr_n_nxt = (state_nxt != FXC_WR_LOW);
      rd_n_nxt = (state_nxt != FXC_RD_LOW);
      mc_n_nxt = (state_nxt != FXC_CLEAR);
      rt_n_nxt = (state_nxt != FXC_RT_LOW);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r    <= FXC_CLEAR;
         cnt_r      <= CLEAR_CYC;
         wdata_r    <= '0;
         odata_r    <= '0;
         ovalid_r   <= 1'h0;
         prio_rd_r  <= 1'h0;
         clr_pend_r <= 1'h0;
         rt_pend_r  <= 1'h0;
         done_r     <= 1'h0;
         wr_n_r     <= PIN_INACTIVE;
         rd_n_r     <= PIN_INACTIVE;
         mc_n_r     <= CLEAR_ASSERT;
         rt_n_r     <= PIN_INACTIVE;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         wdata_r    <= wdata_nxt;
         odata_r    <= odata_nxt;
         ovalid_r   <= ovalid_nxt;
         prio_rd_r  <= prio_rd_nxt;
         clr_pend_r <= clr_pend_nxt;
         rt_pend_r  <= rt_pend_nxt;
         done_r     <= done_nxt;
         wr_n_r     <= wr_n_nxt;
         rd_n_r     <= rd_n_nxt;
         mc_n_r     <= mc_n_nxt;
         rt_n_r     <= rt_n_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign write_n                = wr_n_r;
   assign read_n                 = rd_n_r;
   assign master_clear_n         = mc_n_r;
   assign first_load_or_rewind_n = rt_n_r;
   assign chain_input_n          = SINGLE_MODE; // Single device only, so rewind is usable
   assign write_bus              = wdata_r;
   assign out_data               = odata_r;
   assign out_valid              = ovalid_r;
   assign busy                   = (state_r != FXC_IDLE);
   assign dev_ready              = done_r;
   assign dev_empty              = !empty_n_s;
   assign dev_full               = !full_n_s;
   assign dev_half               = !half_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Pin age counters, read only by the checks below
   logic [CNT_W-1:0] wr_age_r, wr_age_nxt, rd_age_r, rd_age_nxt, rt_age_r, rt_age_nxt;

   always_comb begin
      wr_age_nxt = (wr_n_nxt != wr_n_r) ? 8'h01 : sat_inc(wr_age_r);
      rd_age_nxt = (rd_n_nxt != rd_n_r) ? 8'h01 : sat_inc(rd_age_r);
      rt_age_nxt = (rt_n_nxt != rt_n_r) ? 8'h01 : sat_inc(rt_age_r);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_age_r <= 8'h01;
         rd_age_r <= 8'h01;
         rt_age_r <= 8'h01;
      end else begin
         wr_age_r <= wr_age_nxt;
         rd_age_r <= rd_age_nxt;
         rt_age_r <= rt_age_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_clear_before_write: assert property ($fell(write_n) |-> dev_ready)
      else $error("write strobe before first master clear");
   chk_strobes_in_clear: assert property (!master_clear_n |-> write_n && read_n)
      else $error("strobe active during master clear");
   chk_clear_recovery: assert property ($rose(master_clear_n) |-> (write_n && read_n)[*4])
      else $error("strobe active within clear recovery");
   chk_write_not_full: assert property ($fell(write_n) |-> $past(full_n_s))
      else $error("write started while device full");
   chk_write_data_hold: assert property (!$past(write_n) |-> $stable(write_bus))
      else $error("write data moved during or at end of strobe");
   chk_rewind_quiet: assert property (!first_load_or_rewind_n |-> write_n && read_n)
      else $error("strobe active during rewind");
   chk_write_width: assert property ($rose(write_n) |-> $past(wr_age_r) == STROBE_CYC)
      else $error("write strobe width wrong");
   chk_read_width: assert property ($rose(read_n) |-> $past(rd_age_r) == RD_LOW_CYC)
      else $error("read strobe width wrong");
   chk_rewind_width: assert property ($rose(first_load_or_rewind_n) |-> $past(rt_age_r) == REWIND_CYC)
      else $error("rewind pulse width wrong");
   chk_strobe_gap: assert property ($fell(write_n) |-> $past(wr_age_r) >= REC_CYC)
      else $error("write strobe high gap too short");
   chk_one_strobe: assert property (!(!write_n && !read_n))
      else $error("both strobes low together");
endmodule
`default_nettype wire

//--- verification/fxc_dev_model.sv
// Behavioural strobe FIFO device seen from the controller's pins
`timescale 1ns/1ps
`default_nettype none
module fxc_dev_model
   import fxc_pkg::*;
#(
   parameter int unsigned DEPTH   = 512, // 512 or 1024 words
   parameter int unsigned FLAG_NS = 20   // Strobe edge to flag delay
) (
   input  wire logic              write_n,                // Write strobe
   input  wire logic              read_n,                 // Read strobe
   input  wire logic              master_clear_n,         // Master clear
   input  wire logic              first_load_or_rewind_n, // Rewind
   input  wire logic              chain_input_n,          // Chain input
   input  wire logic [DATA_W-1:0] write_bus,              // Write data
   output logic [DATA_W-1:0]      read_bus,               // Read data
   output logic                   empty_flag_n,           // Empty flag
   output logic                   full_flag_n,            // Full flag
   output logic                   half_mark_n             // Half mark
);
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] last_q = '0;
   int unsigned       wp = 0;
   int unsigned       rp = 0;
   int unsigned       count = 0;
   logic              wr_go = 1'b0;
   logic              rd_go = 1'b0;
   ////////////////////////////////////////////////////////////////
   // Flags follow occupancy after a delay, so a stale sample is possible
   assign #(FLAG_NS) empty_flag_n = (count != 0);
   assign #(FLAG_NS) full_flag_n  = (count != DEPTH);
   assign #(FLAG_NS) half_mark_n  = (count <= DEPTH / 2);
   // A released bus shows the inverse of the last word, never a copy
   assign read_bus = (!read_n && rd_go) ? mem[rp] : ~last_q;
   // Clear returns both pointers to the start
   always @(negedge master_clear_n) begin
      wp = 0;
      rp = 0;
      count = 0;
   end
   // Write armed on the falling edge, stored on the rising edge
   always @(negedge write_n) begin
      wr_go = master_clear_n && (count < DEPTH);
   end
   always @(posedge write_n) begin
      if (wr_go) begin
         mem[wp] = write_bus;
         wp = (wp + 1) % DEPTH;
         count = count + 1;
      end
      wr_go = 1'b0;
   end
   // Read armed only while something is stored
   always @(negedge read_n) begin
      rd_go = master_clear_n && (count != 0);
   end
   always @(posedge read_n) begin
      if (rd_go) begin
         last_q = mem[rp];
         rp = (rp + 1) % DEPTH;
         count = count - 1;
      end
      rd_go = 1'b0;
   end
   // Rewind only in single mode; occupancy is exact only before the ring wraps
   always @(negedge first_load_or_rewind_n) begin
      if (chain_input_n == SINGLE_MODE) begin
         rp = 0;
         count = wp;
      end
   end
endmodule
`default_nettype wire

//--- verification/test_fxc_ctrl.sv
// Self-checking bench: pin controller against the device model
`timescale 1ns/1ps
`default_nettype none
module test_fxc_ctrl
   import fxc_pkg::*;
;
   localparam int unsigned DEPTH = 512;
   logic              clk, arst_n, in_valid, in_ready, rd_req, out_valid, clear_req, rewind_req;
   logic              busy, dev_ready, dev_empty, dev_full, dev_half, write_n, read_n;
   logic              master_clear_n, first_load_or_rewind_n, chain_input_n;
   logic              empty_flag_n, full_flag_n, half_mark_n;
   logic [DATA_W-1:0] in_data, out_data, write_bus, read_bus, got;
   logic [DATA_W-1:0] words [3] = '{9'h1a5, 9'h05a, 9'h1ff};
   int                mismatches = 0;
   int                comparisons = 0;
   int                wlow = 0;
   int                rlow = 0;
   fxc_ctrl i_fxc_ctrl (.*);
   fxc_dev_model #(.DEPTH(DEPTH)) i_fxc_dev_model (.*);
   ////////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic g, input logic e, input string msg);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string msg);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, g, e);
      end
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Select one design output for the bounded waits
   function automatic logic pick(input int k);
      case (k)
         0: return in_ready;
         1: return out_valid;
         2: return busy;
         3: return dev_ready;
         4: return master_clear_n;
         default: return first_load_or_rewind_n;
      endcase
   endfunction
   // Bounded wait; running out ends the run as a failure
   task automatic wait_bit(input int k, input logic v, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pick(k) !== v && n < lim);
      if (pick(k) !== v) begin
         mismatches++;
         $display("[FAIL] %0t wait ran out", $time);
         give_verdict;
      end
   endtask
   // Offer stays raised so back-to-back pushes never toggle it
   task automatic push_word(input logic [DATA_W-1:0] w);
      in_data  <= w;
      in_valid <= 1'b1;
      wait_bit(0, 1'b1, 100);
   endtask
   task automatic pop_word(output logic [DATA_W-1:0] w);
      @(posedge clk);
      rd_req <= 1'b1;
      wait_bit(1, 1'b1, 300);
      rd_req <= 1'b0;
      w = out_data;
   endtask
   task automatic pulse_req(input int k);
      @(posedge clk);
      if (k == 4) clear_req <= 1'b1; else rewind_req <= 1'b1;
      @(posedge clk);
      clear_req  <= 1'b0;
      rewind_req <= 1'b0;
      wait_bit(k, 1'b0, 20);
      wait_bit(2, 1'b0, 60);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic s_reset;
      @(posedge clk);
      chk_bit(master_clear_n, 1'b0, "no clear after reset");
      chk_bit(chain_input_n, 1'b0, "not single mode");
      wait_bit(3, 1'b1, 60);
      chk_bit(dev_empty, 1'b1, "not empty after clear");
      chk_bit(dev_full | dev_half, 1'b0, "full or half after clear");
   endtask
   task automatic s_order;
      foreach (words[i]) push_word(words[i]);
      in_valid <= 1'b0;
      foreach (words[i]) begin
         pop_word(got);
         chk_word(got, words[i], "read order");
      end
      // Let the last release settle before raising the request again
      @(posedge clk);
      rd_req <= 1'b1;
      repeat (60) begin
         @(posedge clk);
         chk_bit(out_valid, 1'b0, "read from empty device");
      end
      rd_req <= 1'b0;
   endtask
   task automatic s_rewind;
      pulse_req(5);
      chk_bit(dev_empty, 1'b0, "flags after rewind");
      foreach (words[i]) begin
         pop_word(got);
         chk_word(got, words[i], "rewind replay");
      end
   endtask
   task automatic s_fill;
      // Leave a stale word in the device so the clear has something to discard
      push_word(9'h0aa);
      in_valid <= 1'b0;
      repeat (30) @(posedge clk);
      pulse_req(4);
      chk_bit(dev_empty, 1'b1, "clear left data");
      for (int i = 0; i < DEPTH + BUF_DEPTH; i++) push_word(9'(i));
      in_valid <= 1'b0;
      repeat (40) @(posedge clk);
      chk_bit(in_ready, 1'b0, "buffer not refusing");
      chk_bit(dev_full & dev_half, 1'b1, "full or half missing");
      chk_bit(i_fxc_dev_model.count == DEPTH, 1'b1, "device write count");
      pop_word(got);
      chk_word(got, 9'h000, "first word after fill");
      repeat (60) @(posedge clk);
      chk_bit(in_ready & (i_fxc_dev_model.count == DEPTH), 1'b1, "no write after release");
      for (int i = 1; i < DEPTH + BUF_DEPTH; i++) begin
         pop_word(got);
         chk_word(got, 9'(i), "drain order");
      end
      repeat (20) @(posedge clk);
      chk_bit(dev_empty & !dev_half, 1'b1, "flags after drain");
   endtask
   ////////////////////////////////////////////////////////////////
   // Pin watch: pulse widths, quiet strobes under clear and rewind, no write while full
   always @(posedge clk) begin
      if (arst_n) begin
         if (!master_clear_n || !first_load_or_rewind_n) chk_bit(write_n & read_n, 1'b1, "strobe in clear");
         if (write_n && wlow != 0) chk_bit(wlow >= STROBE_CYC, 1'b1, "short write pulse");
         if (read_n && rlow != 0) chk_bit(rlow >= STROBE_CYC, 1'b1, "short read pulse");
      end
      wlow <= write_n ? 0 : wlow + 1;
      rlow <= read_n ? 0 : rlow + 1;
   end
   always @(negedge write_n) begin
      chk_bit(full_flag_n, 1'b1, "write started while full");
   end
   // Clock and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      arst_n = 1'b0;
      in_valid = 1'b0;
      in_data = 9'h000;
      rd_req = 1'b0;
      clear_req = 1'b0;
      rewind_req = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      s_reset;
      s_order;
      s_rewind;
      s_fill;
      give_verdict;
   end
endmodule
`default_nettype wire
